/* hdl/reiu_map.vh */
// register offsets, field positions, reset values and timing counts for the error interrupt unit
`ifndef REIU_MAP_VH
`define REIU_MAP_VH
`define REIU_OFS_STATUS 12'h01C
`define REIU_OFS_CTRL 12'h000
`define REIU_OFS_MASK 12'h004
`define REIU_OFS_STICKY 12'h020
`define REIU_OFS_STREAM 12'h008
`define REIU_BIT_LOCK 0
`define REIU_BIT_PAR 1
`define REIU_BIT_COMP 2
`define REIU_BIT_NONAUD 3
`define REIU_BIT_VALID 4
`define REIU_BIT_RATE 5
`define REIU_BIT_SUBQ 6
`define REIU_BIT_CHST 7
`define REIU_BIT_TAPE 8
`define REIU_CTRL_SERIAL 0
`define REIU_CTRL_GUARD 1
`define REIU_CTRL_HOLD_LO 2
`define REIU_CTRL_HOLD_HI 3
`define REIU_CTRL_RESET 32'h0000_0002
`define REIU_MASK_RESET 32'h0000_0000
`define REIU_HOLD_DEFAULT 2'h1
`define REIU_HOLD_BASE_FS 512
`define REIU_HOLD_MAX_FS 4096
`define REIU_PAR_HOLD_FS 1024
`define REIU_GUARD_FRAMES 3840
`endif

/* hdl/reiu_hold_timer.v */
// retriggerable hold counter, counting frame periods after its source clears
`timescale 1ns/1ps
`default_nettype none
module reiu_hold_timer #(
  parameter W = 13
) (
  input wire clk, // system clock
  input wire rst_n, // asynchronous reset, active low
  input wire tick, // one-cycle frame-period enable
  input wire src, // level to stretch
  input wire [W-1:0] hold_len, // frames to hold after src falls
  output reg out // stretched level
);
  reg [W-1:0] cnt;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= {W{1'b0}};
      out <= 1'b0;
    end else if (src) begin
      cnt <= hold_len;
      out <= 1'b1;
    end else if (out && tick) begin
      if (cnt <= {{(W-1){1'b0}}, 1'b1}) begin
        cnt <= {W{1'b0}};
        out <= 1'b0;
      end else begin
        cnt <= cnt - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule // reiu_hold_timer
`default_nettype wire

/* hdl/reiu_error_irq.v */
// receiver error and event handling with interrupt pins, status registers and output forcing
//
// Function
// - clock recovery off forces both interrupt pins low
// - lock-lost flag is one while recovery loop is out of lock
// - parity flag follows parity or bi-phase error, refreshed each sub-frame
// - compressed-stream flag is OR of nonlinear pcm and cd stream detect
// - validity flag follows received validity, refreshed each sub-frame
// - non-audio flag follows channel-status non-audio bit, refreshed each block
// - rate or emphasis change raises change flag for exactly one sub-frame
// - subcode-change flag sets when new q-subcode differs, once per sync
// - channel-status-change flag sets when status differs, once per block
// - tape marker flag sets; guard ignores repeats within 3840 frames
// - pin mode: error pin is lock|parity, info pin compressed|non-audio
// - pin mode: error pin holds 1024 frames after errors clear
// - audio out low on lock loss, repeats last good on parity error
// - validity pin low while unlocked, otherwise follows validity flag
// - register mode: pins OR unmasked events; masks leave status bits alone
// - register mode: error pin hold programmable, default 1024, max 2048
// - register mode: info pin falls at once when its events clear
// - real-time status bits are not latched
// - sticky change bits hold until software reads their register
// - lock loss resets stored channel status, user bits and burst words
`timescale 1ns/1ps
`default_nettype none
`include "reiu_map.vh"
module reiu_error_irq #(
  parameter HOLD_W = 13, // hold counter width, fits 4096 frames
  parameter GUARD_FRAMES = `REIU_GUARD_FRAMES, // re-trigger guard length in frames
  parameter PAR_HOLD = `REIU_PAR_HOLD_FS, // pin-mode hold in frames
  parameter HOLD_BASE = `REIU_HOLD_BASE_FS, // register-mode hold step in frames
  parameter SUB_W = 24 // sub-frame audio word width
) (
  input wire pclk, // apb clock, 100 MHz
  input wire presetn, // asynchronous reset, active low
  input wire psel, // apb select
  input wire penable, // apb enable
  input wire pwrite, // apb direction
  input wire [11:0] paddr, // apb byte address
  input wire [31:0] pwdata, // apb write data
  output reg [31:0] prdata, // apb read data
  output reg pready, // apb ready
  output reg pslverr, // apb error, unmapped address
  input wire serial_mode_pin, // strap: 1 register-controlled mode
  input wire pll_off, // clock operation mode 1, recovery loop off
  input wire frame_clock, // recovered frame clock pin
  input wire subframe_tick, // one cycle per sub-frame, same clock
  input wire block_tick, // one cycle per channel-status block
  input wire subcode_sync_tick, // one cycle per q-subcode sync
  input wire preamble_err, // preamble spacing or coding wrong
  input wire parity_err, // parity error in this sub-frame
  input wire biphase_err, // bi-phase coding error in this sub-frame
  input wire nonlinear_pcm_detect, // compressed stream detected
  input wire cd_stream_detect, // cd compressed stream detected
  input wire valid_bit, // received validity bit
  input wire non_audio_bit, // non-audio bit of channel status
  input wire [3:0] sample_rate_code, // detected rate code
  input wire preemphasis_bit, // pre-emphasis bit
  input wire [79:0] subcode_q, // newly captured q-subcode
  input wire [39:0] chan_status, // received channel status bits
  input wire tape_category, // category code says tape
  input wire tape_marker_seen, // start marker detected pulse
  input wire [SUB_W-1:0] audio_in, // decoded sub-frame audio
  output reg error_irq_pin, // error interrupt pin
  output reg info_irq_pin, // info interrupt pin
  output reg [SUB_W-1:0] serial_audio_out, // audio data after error handling
  output reg validity_pin, // validity output pin
  output reg store_clear // pulse: clear channel status, user bits, burst words
);
  //////////////////////////////////////////////////////////////////////////////
  // frame clock synchroniser and frame tick
  reg fc_s1, fc_s2, fc_s3;
  reg fc_level;
  reg frame_tick;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fc_s1 <= 1'b0;
      fc_s2 <= 1'b0;
      fc_s3 <= 1'b0;
      fc_level <= 1'b0;
      frame_tick <= 1'b0;
    end else begin
      fc_s1 <= frame_clock;
      fc_s2 <= fc_s1;
      fc_s3 <= fc_s2;
      frame_tick <= 1'b0;
      if (fc_s2 == fc_s3 && fc_s2 != fc_level) begin
        fc_level <= fc_s2;
        frame_tick <= fc_s2;
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // control registers
  reg [31:0] ctrl;
  reg [8:0] mask;
  reg serial_mode;
  wire guard_on = ctrl[`REIU_CTRL_GUARD];
  wire [1:0] hold_sel = ctrl[`REIU_CTRL_HOLD_HI:`REIU_CTRL_HOLD_LO];
  wire wr_en = psel && penable && pwrite;
  wire rd_en = psel && penable && !pwrite;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `REIU_CTRL_RESET | {28'h0, `REIU_HOLD_DEFAULT, 2'h0};
      mask <= 9'h000;
      serial_mode <= 1'b0;
    end else begin
      serial_mode <= serial_mode_pin;
      if (wr_en && paddr == `REIU_OFS_CTRL)
        ctrl <= {28'h0, pwdata[3:0]};
      if (wr_en && paddr == `REIU_OFS_MASK)
        mask <= pwdata[8:0];
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // event flags
  reg lock_lost_flag, parity_biphase_err_flag, valid_flag, non_audio_flag;
  reg rate_emph_change_flag;
  reg [4:0] last_rate;
  reg [79:0] last_q;
  reg [39:0] last_cs;
  reg subcode_change_flag, chan_status_change_flag, tape_start_marker_flag;
  reg [12:0] guard_cnt;
  wire comp_flag = nonlinear_pcm_detect | cd_stream_detect;
  wire q_diff = subcode_sync_tick && subcode_q != last_q;
  wire cs_diff = block_tick && chan_status != last_cs && !lock_lost_flag;
  wire guard_busy = guard_on && guard_cnt != 13'h0000;
  wire tape_hit = tape_category && tape_marker_seen && !guard_busy;
  wire sticky_rd = rd_en && paddr == `REIU_OFS_STICKY;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_lost_flag <= 1'b0;
      parity_biphase_err_flag <= 1'b0;
      valid_flag <= 1'b0;
      non_audio_flag <= 1'b0;
      rate_emph_change_flag <= 1'b0;
      last_rate <= 5'h00;
      last_q <= 80'h0;
      last_cs <= 40'h0;
      subcode_change_flag <= 1'b0;
      chan_status_change_flag <= 1'b0;
      tape_start_marker_flag <= 1'b0;
      guard_cnt <= 13'h0000;
      store_clear <= 1'b0;
    end else begin
      lock_lost_flag <= preamble_err;
      store_clear <= preamble_err && !lock_lost_flag;
      if (subframe_tick) begin
        parity_biphase_err_flag <= parity_err | biphase_err;
        valid_flag <= valid_bit;
        rate_emph_change_flag <= {sample_rate_code, preemphasis_bit} != last_rate;
        last_rate <= {sample_rate_code, preemphasis_bit};
      end
      if (block_tick)
        non_audio_flag <= non_audio_bit;
      if (preamble_err) begin
        last_cs <= 40'h0;
        non_audio_flag <= 1'b0;
      end else if (block_tick) begin
        last_cs <= chan_status;
      end
      if (subcode_sync_tick)
        last_q <= subcode_q;
      // sticky bits: set beats the clear from a read in the same cycle
      // only bits that the captured read data showed are cleared, so an event
      // landing between setup and access edge survives for the next read
      if (q_diff)
        subcode_change_flag <= 1'b1;
      else if (sticky_rd && prdata[`REIU_BIT_SUBQ])
        subcode_change_flag <= 1'b0;
      if (cs_diff)
        chan_status_change_flag <= 1'b1;
      else if (sticky_rd && prdata[`REIU_BIT_CHST])
        chan_status_change_flag <= 1'b0;
      if (tape_hit)
        tape_start_marker_flag <= 1'b1;
      else if (sticky_rd && prdata[`REIU_BIT_TAPE])
        tape_start_marker_flag <= 1'b0;
      // guard counts frames from the last accepted marker
      if (tape_hit)
        guard_cnt <= GUARD_FRAMES[12:0];
      else if (frame_tick && guard_cnt != 13'h0000)
        guard_cnt <= guard_cnt - 13'h0001;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // interrupt pins
  wire [8:0] events = {tape_start_marker_flag, chan_status_change_flag, subcode_change_flag,
    rate_emph_change_flag, valid_flag, non_audio_flag, comp_flag,
    parity_biphase_err_flag, lock_lost_flag};
  wire [8:0] live = events & ~mask;
  wire err_src_pin = lock_lost_flag | parity_biphase_err_flag;
  wire info_src_pin = comp_flag | non_audio_flag;
  wire err_src = serial_mode ? (live[`REIU_BIT_LOCK] | live[`REIU_BIT_PAR]) : err_src_pin;
  wire info_src = serial_mode ? (|live[8:2]) : info_src_pin;
  reg [HOLD_W-1:0] hold_len;
  always @* begin
    hold_len = PAR_HOLD[HOLD_W-1:0];
    if (serial_mode)
      hold_len = HOLD_BASE[HOLD_W-1:0] * ({{(HOLD_W-2){1'b0}}, hold_sel} +
        {{(HOLD_W-1){1'b0}}, 1'b1});
  end
  wire err_held;
  reiu_hold_timer #(.W(HOLD_W)) u_hold (
    .clk(pclk),
    .rst_n(presetn),
    .tick(frame_tick),
    .src(err_src),
    .hold_len(hold_len),
    .out(err_held)
  );
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      error_irq_pin <= 1'b0;
      info_irq_pin <= 1'b0;
    end else begin
      error_irq_pin <= err_held && !pll_off;
      info_irq_pin <= info_src && !pll_off;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // audio and validity output forcing
  reg [SUB_W-1:0] last_good;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_good <= {SUB_W{1'b0}};
      serial_audio_out <= {SUB_W{1'b0}};
      validity_pin <= 1'b0;
    end else begin
      if (subframe_tick && !(parity_err | biphase_err) && !preamble_err)
        last_good <= audio_in;
      if (lock_lost_flag)
        serial_audio_out <= {SUB_W{1'b0}};
      else if (parity_biphase_err_flag)
        serial_audio_out <= last_good;
      else
        serial_audio_out <= audio_in;
      validity_pin <= lock_lost_flag ? 1'b0 : valid_flag;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // apb slave, zero wait states
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        case (paddr)
          `REIU_OFS_CTRL: prdata <= ctrl;
          `REIU_OFS_MASK: prdata <= {23'h0, mask};
          `REIU_OFS_STATUS: prdata <= {23'h0, events};
          `REIU_OFS_STICKY: prdata <= {23'h0, events[8:6], 6'h00};
          default: begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end
endmodule // reiu_error_irq
`default_nettype wire

/* testbench/reiu_error_irq_asserts.sv */
// checker bound to the error interrupt unit ports
`timescale 1ns/1ps
`default_nettype none
module reiu_error_irq_asserts (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr, // error answer
  input wire logic serial_mode_pin, // mode strap
  input wire logic pll_off, // recovery loop off
  input wire logic preamble_err, // lock lost
  input wire logic nonlinear_pcm_detect, // compressed stream
  input wire logic error_irq_pin, // error pin
  input wire logic info_irq_pin, // info pin
  input wire logic [23:0] serial_audio_out, // audio out
  input wire logic validity_pin, // validity out
  input wire logic store_clear // store clear pulse
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////////
  a_pll_off_quiet: assert property (pll_off && $past(pll_off) |-> !error_irq_pin && !info_irq_pin)
    else $error("irq pin high while recovery is off");
  a_unlock_mute: assert property (preamble_err [*4] |-> !(|serial_audio_out) && !validity_pin)
    else $error("audio or validity not forced low while unlocked");
  a_unlock_clear: assert property ($rose(preamble_err) |-> ##[1:3] store_clear)
    else $error("no store clear after lock loss");
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready stood two cycles");
  a_slverr_data: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("error answer without zero data");
  // hold is at least several frames, so a fall this close to lock loss is a slip
  a_hold_after_loss: assert property ($fell(error_irq_pin) && !pll_off && !$past(pll_off) &&
    !$past(pll_off, 2) |-> !$past(preamble_err, 8))
    else $error("error pin fell without hold");
  a_pin_mode_err: assert property ((!serial_mode_pin && preamble_err && !pll_off) [*4]
    |-> error_irq_pin)
    else $error("error pin low with lock lost");
  a_pin_mode_info: assert property ((!serial_mode_pin && nonlinear_pcm_detect && !pll_off) [*4]
    |-> info_irq_pin)
    else $error("info pin low with compressed stream");
endmodule // reiu_error_irq_asserts
`default_nettype wire

/* testbench/reiu_host_model.sv */
// host side model that watches the error interrupt pin
`timescale 1ns/1ps
`default_nettype none
module reiu_host_model (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic error_irq_pin, // error pin
  output logic [7:0] err_rises // error pin assertions seen
);
  logic err_d;
  // counts assertions, not level, so a held pin is one event for the host
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_d <= 1'b0;
      err_rises <= 8'h00;
    end else begin
      err_d <= error_irq_pin;
      if (error_irq_pin && !err_d) begin
        err_rises <= err_rises + 8'h01;
      end
    end
  end
endmodule // reiu_host_model
`default_nettype wire

/* testbench/reiu_error_irq_bench.sv */
// self-checking bench for the error interrupt unit over apb
`timescale 1ns/1ps
`default_nettype none
`include "reiu_map.vh"
module reiu_error_irq_bench;
  logic pclk, presetn, psel, penable, pwrite, serial_mode_pin, pll_off, subframe_tick;
  logic block_tick, subcode_sync_tick, preamble_err, parity_err, biphase_err, valid_bit;
  logic nonlinear_pcm_detect, cd_stream_detect, non_audio_bit, preemphasis_bit, tape_category;
  logic tape_marker_seen, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, rdat;
  logic [3:0] sample_rate_code;
  logic [79:0] subcode_q;
  logic [39:0] chan_status;
  logic [23:0] audio_in;
  logic [2:0] fdiv = 3'h0;
  wire [31:0] prdata;
  wire [23:0] serial_audio_out;
  wire [7:0] err_rises;
  wire frame_clock, pready, pslverr, error_irq_pin, info_irq_pin, validity_pin, store_clear;
  int bad_count = 0;
  int checks_done = 0;
  assign frame_clock = fdiv[2];
  always @(posedge pclk) fdiv <= fdiv + 3'h1;
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  reiu_error_irq #(.GUARD_FRAMES(20), .PAR_HOLD(8), .HOLD_BASE(4)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_mode_pin(serial_mode_pin), .pll_off(pll_off), .frame_clock(frame_clock),
    .subframe_tick(subframe_tick), .block_tick(block_tick), .subcode_sync_tick(subcode_sync_tick),
    .preamble_err(preamble_err), .parity_err(parity_err), .biphase_err(biphase_err),
    .nonlinear_pcm_detect(nonlinear_pcm_detect), .cd_stream_detect(cd_stream_detect),
    .valid_bit(valid_bit), .non_audio_bit(non_audio_bit), .sample_rate_code(sample_rate_code),
    .preemphasis_bit(preemphasis_bit), .subcode_q(subcode_q), .chan_status(chan_status),
    .tape_category(tape_category), .tape_marker_seen(tape_marker_seen), .audio_in(audio_in),
    .error_irq_pin(error_irq_pin), .info_irq_pin(info_irq_pin), .validity_pin(validity_pin),
    .serial_audio_out(serial_audio_out), .store_clear(store_clear));
  reiu_host_model i_host (.pclk(pclk), .presetn(presetn), .error_irq_pin(error_irq_pin),
    .err_rises(err_rises));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] bitv(input int b);
    return 32'h0000_0001 << b;
  endfunction
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chkb(input string what, input logic exp, input logic got);
    chk(what, {31'h0, exp}, {31'h0, got});
  endtask
  // request held until ready is sampled high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      bad_count++;
      end_of_test();
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic err);
    apb(1'b0, a, 32'h0000_0000);
    chk("prdata", exp, rdat);
    chkb("pslverr", err, rerr);
  endtask
  task automatic pulse(input int k);
    @(posedge pclk);
    case (k)
      0: subframe_tick <= 1'b1;
      1: block_tick <= 1'b1;
      2: subcode_sync_tick <= 1'b1;
      default: tape_marker_seen <= 1'b1;
    endcase
    @(posedge pclk);
    {subframe_tick, block_tick, subcode_sync_tick, tape_marker_seen} <= 4'h0;
    cyc(3);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {psel, penable, pwrite, paddr, pwdata, serial_mode_pin, pll_off, subframe_tick, block_tick,
      subcode_sync_tick, preamble_err, parity_err, biphase_err, nonlinear_pcm_detect,
      cd_stream_detect, valid_bit, non_audio_bit, sample_rate_code, preemphasis_bit, subcode_q,
      chan_status, tape_category, tape_marker_seen, audio_in, presetn} = '0;
    cyc(8);
    presetn <= 1'b1;
    cyc(2);
    chkb("error_irq_pin", 1'b0, error_irq_pin);
    rd(`REIU_OFS_CTRL, `REIU_CTRL_RESET | (`REIU_HOLD_DEFAULT << `REIU_CTRL_HOLD_LO), 1'b0);
    rd(`REIU_OFS_MASK, `REIU_MASK_RESET, 1'b0);
    rd(12'h100, 32'h0000_0000, 1'b1);
    audio_in <= 24'h123456;
    pulse(0);
    chk("serial_audio_out", 32'h0012_3456, {8'h00, serial_audio_out});
    preamble_err <= 1'b1;
    cyc(6);
    chkb("error_irq_pin", 1'b1, error_irq_pin);
    chkb("validity_pin", 1'b0, validity_pin);
    preamble_err <= 1'b0;
    cyc(20);
    chkb("error_irq_pin", 1'b1, error_irq_pin);
    cyc(100);
    chkb("error_irq_pin", 1'b0, error_irq_pin);
    nonlinear_pcm_detect <= 1'b1;
    cyc(4);
    chkb("info_irq_pin", 1'b1, info_irq_pin);
    nonlinear_pcm_detect <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      audio_in <= 24'h111111;
      pulse(0);
      parity_err <= (k == 0);
      biphase_err <= (k == 1);
      audio_in <= 24'hABCDEF;
      pulse(0);
      chk("serial_audio_out", 32'h0011_1111, {8'h00, serial_audio_out});
      {parity_err, biphase_err} <= 2'h0;
      pulse(0);
      chk("serial_audio_out", 32'h00AB_CDEF, {8'h00, serial_audio_out});
      cyc(100);
    end
    pll_off <= 1'b1;
    cd_stream_detect <= 1'b1;
    cyc(2);
    preamble_err <= 1'b1;
    cyc(6);
    chkb("error_irq_pin", 1'b0, error_irq_pin);
    chkb("info_irq_pin", 1'b0, info_irq_pin);
    {preamble_err, cd_stream_detect} <= 2'h0;
    cyc(100);
    pll_off <= 1'b0;
    serial_mode_pin <= 1'b1;
    apb(1'b1, `REIU_OFS_CTRL, 32'h0000_0002);
    cd_stream_detect <= 1'b1;
    cyc(4);
    rd(`REIU_OFS_STATUS, bitv(`REIU_BIT_COMP), 1'b0);
    chkb("info_irq_pin", 1'b1, info_irq_pin);
    cd_stream_detect <= 1'b0;
    cyc(3);
    chkb("info_irq_pin", 1'b0, info_irq_pin);
    rd(`REIU_OFS_STATUS, 32'h0000_0000, 1'b0);
    apb(1'b1, `REIU_OFS_MASK, bitv(`REIU_BIT_COMP));
    cd_stream_detect <= 1'b1;
    cyc(4);
    chkb("info_irq_pin", 1'b0, info_irq_pin);
    rd(`REIU_OFS_STATUS, bitv(`REIU_BIT_COMP), 1'b0);
    cd_stream_detect <= 1'b0;
    apb(1'b1, `REIU_OFS_MASK, 32'h0000_0000);
    valid_bit <= 1'b1;
    pulse(0);
    rd(`REIU_OFS_STATUS, bitv(`REIU_BIT_VALID), 1'b0);
    chkb("validity_pin", 1'b1, validity_pin);
    valid_bit <= 1'b0;
    pulse(0);
    for (int k = 0; k < 2; k++) begin
      if (k == 0) sample_rate_code <= 4'h3;
      else preemphasis_bit <= 1'b1;
      pulse(0);
      rd(`REIU_OFS_STATUS, bitv(`REIU_BIT_RATE), 1'b0);
      pulse(0);
      rd(`REIU_OFS_STATUS, 32'h0000_0000, 1'b0);
    end
    non_audio_bit <= 1'b1;
    pulse(1);
    rd(`REIU_OFS_STATUS, bitv(`REIU_BIT_NONAUD), 1'b0);
    non_audio_bit <= 1'b0;
    pulse(1);
    chan_status <= 40'h00_0000_0001;
    pulse(1);
    rd(`REIU_OFS_STICKY, bitv(`REIU_BIT_CHST), 1'b0);
    rd(`REIU_OFS_STICKY, 32'h0000_0000, 1'b0);
    subcode_q <= 80'h1;
    pulse(2);
    rd(`REIU_OFS_STICKY, bitv(`REIU_BIT_SUBQ), 1'b0);
    tape_category <= 1'b1;
    pulse(3);
    rd(`REIU_OFS_STICKY, bitv(`REIU_BIT_TAPE), 1'b0);
    pulse(3);
    rd(`REIU_OFS_STICKY, 32'h0000_0000, 1'b0);
    cyc(200);
    pulse(3);
    rd(`REIU_OFS_STICKY, bitv(`REIU_BIT_TAPE), 1'b0);
    apb(1'b1, `REIU_OFS_CTRL, bitv(`REIU_CTRL_HOLD_LO));
    pulse(3);
    rd(`REIU_OFS_STICKY, bitv(`REIU_BIT_TAPE), 1'b0);
    preamble_err <= 1'b1;
    cyc(6);
    preamble_err <= 1'b0;
    cyc(40);
    chkb("error_irq_pin", 1'b1, error_irq_pin);
    cyc(60);
    chkb("error_irq_pin", 1'b0, error_irq_pin);
    chk("err_rises", 32'h0000_0004, {24'h0, err_rises});
    end_of_test();
  end
endmodule // reiu_error_irq_bench
bind reiu_error_irq reiu_error_irq_asserts i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .serial_mode_pin(serial_mode_pin), .pll_off(pll_off), .preamble_err(preamble_err),
  .nonlinear_pcm_detect(nonlinear_pcm_detect), .error_irq_pin(error_irq_pin),
  .info_irq_pin(info_irq_pin), .serial_audio_out(serial_audio_out),
  .validity_pin(validity_pin), .store_clear(store_clear));
`default_nettype wire
